// ---- hw/cex_pkg.sv ----
// Package with constants, states and pin carrier of the execute sequencer.
package cex_pkg;

  // Machine cycle is eight clocks; phases are counted 0 to 7.
  localparam int         PH_W       = 3;
  localparam logic [2:0] PH_ZERO    = 3'h0;
  localparam logic [2:0] PH_ONE     = 3'h1;
  localparam logic [2:0] PH_TPF     = 3'h1;
  localparam logic [2:0] PH_RD      = 3'h1;
  localparam logic [2:0] PH_WR_FROM = 3'h4;
  localparam logic [2:0] PH_WR_TO   = 3'h6;
  localparam logic [2:0] PH_TPS     = 3'h6;
  localparam logic [2:0] PH_LAST    = 3'h7;

  // Opcode groups and selectors.
  localparam logic [3:0] GRP_IMM              = 4'hF;
  localparam logic [3:0] N_LOAD_IMMEDIATE     = 4'h8;
  localparam logic [3:0] N_OR_IMMEDIATE       = 4'h9;
  localparam logic [3:0] N_AND_IMMEDIATE      = 4'hA;
  localparam logic [3:0] N_XOR_IMMEDIATE      = 4'hB;
  localparam logic [3:0] N_ADD_IMMEDIATE      = 4'hC;
  localparam logic [3:0] N_SUB_FROM_IMMEDIATE = 4'hD;
  localparam logic [3:0] N_SHIFT_LEFT         = 4'hE;
  localparam logic [3:0] N_SUB_IMMEDIATE      = 4'hF;
  localparam logic [7:0] OP_IDLE              = 8'h00;

  // Register selectors and reset values.
  localparam logic [3:0]  PTR_DMA = 4'h0;
  localparam logic [3:0]  IRQ_P   = 4'h1;
  localparam logic [3:0]  IRQ_X   = 4'h2;
  localparam logic [15:0] INC     = 16'h0001;
  localparam logic [15:0] RF_RST  = 16'h0000;

  // State codes shown on the state output.
  localparam logic [1:0] SC_FETCH = 2'h0;
  localparam logic [1:0] SC_EXEC  = 2'h1;
  localparam logic [1:0] SC_DMA   = 2'h2;
  localparam logic [1:0] SC_IRQ   = 2'h3;

  typedef enum logic [2:0] {
    ST_INIT  = 3'h0,
    ST_FETCH = 3'h1,
    ST_EXEC  = 3'h3,
    ST_DMA   = 3'h2,
    ST_IRQ   = 3'h6
  } state_t;

  typedef struct packed {
    logic       clear_n;
    logic       wait_n;
    logic       dma_in_req;
    logic       dma_out_req;
    logic       irq_req;
    logic [7:0] data;
  } pins_t;

  // Pins at reset: clear asserted, wait released, so the sequencer starts in reset mode.
  localparam logic [12:0] PINS_RST = 13'h0800;

  function automatic logic [3:0] op_group(input logic [7:0] op);
    return op[7:4];
  endfunction : op_group

  function automatic logic [3:0] op_sel(input logic [7:0] op);
    return op[3:0];
  endfunction : op_sel

  function automatic logic [1:0] state_code(input state_t st);
    case (st)
      ST_FETCH: return SC_FETCH;
      ST_DMA:   return SC_DMA;
      ST_IRQ:   return SC_IRQ;
      default:  return SC_EXEC;
    endcase
  endfunction : state_code

endpackage : cex_pkg

// ---- hw/cex_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs.
module cex_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : cex_sync

// ---- hw/cex_alu.sv ----
// Immediate logic, add, subtract and left-shift unit for the accumulator.
module cex_alu (
  input  wire logic [3:0] i_sel,
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_mem,
  input  wire logic       i_carry,
  output logic      [7:0] o_res,
  output logic            o_carry
);

  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    return {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction : add9

  always_comb
  begin
    logic [8:0] sum;
    sum     = 9'h000;
    o_res   = i_acc;
    o_carry = i_carry;
    case (i_sel)
      cex_pkg::N_LOAD_IMMEDIATE: o_res = i_mem;
      cex_pkg::N_OR_IMMEDIATE:   o_res = i_mem | i_acc;
      cex_pkg::N_AND_IMMEDIATE:  o_res = i_mem & i_acc;
      cex_pkg::N_XOR_IMMEDIATE:  o_res = i_mem ^ i_acc;
      cex_pkg::N_ADD_IMMEDIATE:
      begin
        sum     = add9(i_mem, i_acc, 1'b0);
        o_res   = sum[7:0];
        o_carry = sum[8];
      end
      cex_pkg::N_SUB_FROM_IMMEDIATE:
      begin
        // Carry set means no borrow.
        sum     = add9(i_mem, ~i_acc, 1'b1);
        o_res   = sum[7:0];
        o_carry = sum[8];
      end
      cex_pkg::N_SUB_IMMEDIATE:
      begin
        sum     = add9(i_acc, ~i_mem, 1'b1);
        o_res   = sum[7:0];
        o_carry = sum[8];
      end
      cex_pkg::N_SHIFT_LEFT:
      begin
        o_res   = {i_acc[6:0], 1'b0};
        o_carry = i_acc[7];
      end
      default: ;
    endcase
  end

endmodule : cex_alu

// ---- hw/cex_exec.sv ----
// Execute-state sequencer: immediate ALU ops, shift, DMA, interrupt entry and load idle.
module cex_exec (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clear_n,
  input  wire logic        i_wait_n,
  input  wire logic        i_dma_in_req,
  input  wire logic        i_dma_out_req,
  input  wire logic        i_irq_req,
  input  wire logic [7:0]  i_data,
  output logic      [15:0] o_addr,
  output logic             o_mem_read_n,
  output logic             o_mem_write_n,
  output logic             o_timing_pulse_first,
  output logic             o_timing_pulse_second,
  output logic      [1:0]  o_state_code,
  output logic      [7:0]  o_acc,
  output logic             o_carry_flag,
  output logic             o_irq_enable
);

  cex_pkg::pins_t             pin;
  cex_pkg::state_t            state_reg;
  cex_pkg::state_t            state_next;
  logic [cex_pkg::PH_W-1:0]   phase_reg;
  logic [cex_pkg::PH_W-1:0]   phase_next;
  logic [7:0]                 opc_reg;
  logic [7:0]                 opc_next;
  logic [7:0]                 acc_reg;
  logic [7:0]                 acc_next;
  logic                       carry_reg;
  logic                       carry_next;
  logic                       irq_en_reg;
  logic                       irq_en_next;
  logic [3:0]                 x_reg;
  logic [3:0]                 x_next;
  logic [3:0]                 p_reg;
  logic [3:0]                 p_next;
  logic [7:0]                 t_reg;
  logic [7:0]                 t_next;
  logic                       dir_in_reg;
  logic                       dir_in_next;
  logic [15:0]                rf_reg [16];
  logic                       rf_we;
  logic [3:0]                 rf_idx;
  logic [15:0]                rf_val;
  logic [15:0]                addr_reg;
  logic [15:0]                addr_next;
  logic                       rd_n_reg;
  logic                       rd_n_next;
  logic                       wr_n_reg;
  logic                       wr_n_next;
  logic                       tpf_reg;
  logic                       tpf_next;
  logic                       tps_reg;
  logic                       tps_next;
  logic [1:0]                 sc_reg;
  logic [1:0]                 sc_next;
  logic [7:0]                 alu_res;
  logic                       alu_carry;
  logic                       load_mode;
  logic                       clear_mode;
  logic                       advance;
  logic                       cyc_end;
  logic                       is_imm;
  logic                       is_shift;
  logic                       rd_cycle;
  logic                       wr_cycle;

  cex_sync #(
    .W       ($bits(cex_pkg::pins_t)),
    .RST_VAL (cex_pkg::PINS_RST)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_clear_n, i_wait_n, i_dma_in_req, i_dma_out_req, i_irq_req, i_data}),
    .o_sync    (pin)
  );

  cex_alu u_alu (
    .i_sel   (cex_pkg::op_sel(opc_reg)),
    .i_acc   (acc_reg),
    .i_mem   (pin.data),
    .i_carry (carry_reg),
    .o_res   (alu_res),
    .o_carry (alu_carry)
  );

  assign load_mode  = !pin.clear_n && !pin.wait_n;
  assign clear_mode = !pin.clear_n && pin.wait_n;
  // Wait alone freezes the machine cycle; in load mode the cycle keeps running.
  assign advance    = pin.wait_n || load_mode;
  assign cyc_end    = advance && !clear_mode && (phase_reg == cex_pkg::PH_LAST);
  assign is_imm     = (cex_pkg::op_group(opc_reg) == cex_pkg::GRP_IMM) && opc_reg[3]
                      && (cex_pkg::op_sel(opc_reg) != cex_pkg::N_SHIFT_LEFT);
  assign is_shift   = (cex_pkg::op_group(opc_reg) == cex_pkg::GRP_IMM)
                      && (cex_pkg::op_sel(opc_reg) == cex_pkg::N_SHIFT_LEFT);

  // Address, strobe and pulse outputs for the current machine cycle.
  always_comb
  begin
    rd_cycle  = 1'b0;
    wr_cycle  = 1'b0;
    addr_next = rf_reg[cex_pkg::PTR_DMA];
    case (state_reg)
      cex_pkg::ST_FETCH:
      begin
        rd_cycle  = 1'b1;
        addr_next = rf_reg[p_reg];
      end
      cex_pkg::ST_EXEC:
        if (load_mode)
        begin
          rd_cycle  = 1'b1;
          addr_next = rf_reg[cex_pkg::PTR_DMA] - cex_pkg::INC;
        end
        else if (is_imm)
        begin
          rd_cycle  = 1'b1;
          addr_next = rf_reg[p_reg];
        end
        else if (is_shift)
          addr_next = rf_reg[p_reg];
      cex_pkg::ST_DMA:
      begin
        rd_cycle = !dir_in_reg;
        wr_cycle = dir_in_reg;
      end
      cex_pkg::ST_IRQ: addr_next = rf_reg[cex_pkg::op_sel(opc_reg)];
      default: ;
    endcase
    rd_n_next = !(rd_cycle && (phase_reg >= cex_pkg::PH_RD));
    wr_n_next = !(wr_cycle && (phase_reg >= cex_pkg::PH_WR_FROM)
                  && (phase_reg <= cex_pkg::PH_WR_TO));
    tpf_next  = advance && !clear_mode && (phase_reg == cex_pkg::PH_TPF)
                && (state_reg != cex_pkg::ST_INIT)
                && !(load_mode && (state_reg == cex_pkg::ST_EXEC));
    tps_next  = advance && !clear_mode && (phase_reg == cex_pkg::PH_TPS)
                && (state_reg != cex_pkg::ST_INIT);
    sc_next   = cex_pkg::state_code(state_reg);
  end

  // Clear-mode reset on every clock; sequencing and register updates at the end of each machine cycle.
  always_comb
  begin
    state_next  = state_reg;
    phase_next  = phase_reg;
    opc_next    = opc_reg;
    acc_next    = acc_reg;
    carry_next  = carry_reg;
    irq_en_next = irq_en_reg;
    x_next      = x_reg;
    p_next      = p_reg;
    t_next      = t_reg;
    dir_in_next = dir_in_reg;
    rf_we       = 1'b0;
    rf_idx      = cex_pkg::PTR_DMA;
    rf_val      = rf_reg[cex_pkg::PTR_DMA] + cex_pkg::INC;
    if (clear_mode)
    begin
      state_next = cex_pkg::ST_INIT;
      phase_next = cex_pkg::PH_ZERO;
      opc_next   = cex_pkg::OP_IDLE;
      x_next     = 4'h0;
      p_next     = 4'h0;
      rf_we      = 1'b1;
      rf_val     = cex_pkg::RF_RST;
    end
    else if (advance)
    begin
      phase_next = phase_reg + cex_pkg::PH_ONE;
      if (phase_reg == cex_pkg::PH_LAST)
      begin
        case (state_reg)
          cex_pkg::ST_INIT:
          begin
            irq_en_next = 1'b1;
            opc_next   = cex_pkg::OP_IDLE;
            state_next = cex_pkg::ST_EXEC;
          end
          cex_pkg::ST_FETCH:
          begin
            opc_next   = pin.data;
            rf_we      = 1'b1;
            rf_idx     = p_reg;
            rf_val     = rf_reg[p_reg] + cex_pkg::INC;
            state_next = cex_pkg::ST_EXEC;
          end
          cex_pkg::ST_EXEC:
            if (!load_mode && (is_imm || is_shift))
            begin
              acc_next   = alu_res;
              carry_next = alu_carry;
              rf_we      = is_imm;
              rf_idx     = p_reg;
              rf_val     = rf_reg[p_reg] + cex_pkg::INC;
            end
          cex_pkg::ST_DMA:
            rf_we = 1'b1;
          cex_pkg::ST_IRQ:
          begin
            t_next      = {x_reg, p_reg};
            irq_en_next = 1'b0;
            p_next  = cex_pkg::IRQ_P;
            x_next  = cex_pkg::IRQ_X;
          end
          default: state_next = cex_pkg::ST_INIT;
        endcase
        if ((state_reg != cex_pkg::ST_INIT) && (state_reg != cex_pkg::ST_FETCH))
        begin
          if (pin.dma_in_req)
          begin
            state_next  = cex_pkg::ST_DMA;
            dir_in_next = 1'b1;
          end
          else if (pin.dma_out_req)
          begin
            state_next  = cex_pkg::ST_DMA;
            dir_in_next = 1'b0;
          end
          else if (pin.irq_req && irq_en_next && !load_mode)
            state_next = cex_pkg::ST_IRQ;
          else if (load_mode || ((state_reg == cex_pkg::ST_EXEC)
                                 && (opc_reg == cex_pkg::OP_IDLE)))
            state_next = cex_pkg::ST_EXEC;
          else
            state_next = cex_pkg::ST_FETCH;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg  <= cex_pkg::ST_INIT;
      phase_reg  <= cex_pkg::PH_ZERO;
      opc_reg    <= cex_pkg::OP_IDLE;
      acc_reg    <= 8'h00;
      carry_reg  <= 1'b0;
      irq_en_reg <= 1'b0;
      x_reg      <= 4'h0;
      p_reg      <= 4'h0;
      t_reg      <= 8'h00;
      dir_in_reg <= 1'b0;
      addr_reg   <= cex_pkg::RF_RST;
      rd_n_reg   <= 1'b1;
      wr_n_reg   <= 1'b1;
      tpf_reg    <= 1'b0;
      tps_reg    <= 1'b0;
      sc_reg     <= cex_pkg::SC_EXEC;
      for (int i = 0; i < 16; i++)
        rf_reg[i] <= cex_pkg::RF_RST;
    end
    else
    begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      opc_reg    <= opc_next;
      acc_reg    <= acc_next;
      carry_reg  <= carry_next;
      irq_en_reg <= irq_en_next;
      x_reg      <= x_next;
      p_reg      <= p_next;
      t_reg      <= t_next;
      dir_in_reg <= dir_in_next;
      addr_reg   <= addr_next;
      rd_n_reg   <= rd_n_next;
      wr_n_reg   <= wr_n_next;
      tpf_reg    <= tpf_next;
      tps_reg    <= tps_next;
      sc_reg     <= sc_next;
      if (rf_we)
        rf_reg[rf_idx] <= rf_val;
    end
  end

  assign o_addr                = addr_reg;
  assign o_mem_read_n          = rd_n_reg;
  assign o_mem_write_n         = wr_n_reg;
  assign o_timing_pulse_first  = tpf_reg;
  assign o_timing_pulse_second = tps_reg;
  assign o_state_code          = sc_reg;
  assign o_acc                 = acc_reg;
  assign o_carry_flag          = carry_reg;
  assign o_irq_enable          = irq_en_reg;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_imm_end(logic [3:0] n);
    cyc_end && (state_reg == cex_pkg::ST_EXEC) && !load_mode
    && (opc_reg == {cex_pkg::GRP_IMM, n});
  endsequence

  sequence s_dma_end(logic dir);
    cyc_end && (state_reg == cex_pkg::ST_DMA) && (dir_in_reg == dir);
  endsequence

  AST_LOAD_IMMEDIATE: assert property (s_imm_end(cex_pkg::N_LOAD_IMMEDIATE) |=>
    (acc_reg == $past(pin.data))
    && (rf_reg[p_reg] == $past(rf_reg[p_reg]) + cex_pkg::INC))
    else $error("Load-immediate did not load the byte or step the counter.");
  AST_OR_IMMEDIATE: assert property (s_imm_end(cex_pkg::N_OR_IMMEDIATE) |=>
    acc_reg == ($past(acc_reg) | $past(pin.data)))
    else $error("Immediate OR result is wrong.");
  AST_ADD_IMMEDIATE: assert property (s_imm_end(cex_pkg::N_ADD_IMMEDIATE) |=>
    {carry_reg, acc_reg} == ({1'b0, $past(acc_reg)} + {1'b0, $past(pin.data)}))
    else $error("Add-immediate sum or carry is wrong.");
  AST_SUB_IMMEDIATE: assert property (s_imm_end(cex_pkg::N_SUB_IMMEDIATE) |=>
    carry_reg == ($past(acc_reg) >= $past(pin.data)))
    else $error("Subtract-immediate carry is wrong.");
  AST_SHIFT_LEFT: assert property (s_imm_end(cex_pkg::N_SHIFT_LEFT) |=>
    (carry_reg == $past(acc_reg[7])) && (acc_reg == {$past(acc_reg[6:0]), 1'b0}))
    else $error("Shift-left result or carry is wrong.");
  AST_SHIFT_LEFT_FLOAT: assert property ((state_reg == cex_pkg::ST_EXEC) && is_shift
    && !load_mode |=> o_mem_read_n && o_mem_write_n)
    else $error("A strobe was active during shift-left.");
  AST_DMA_IN_WRITE: assert property ((state_reg == cex_pkg::ST_DMA) && dir_in_reg && advance
    && !clear_mode && (phase_reg == cex_pkg::PH_WR_FROM) |=> !o_mem_write_n && o_mem_read_n)
    else $error("DMA in cycle did not assert only the write strobe.");
  AST_DMA_OUT_STEP: assert property (s_dma_end(1'b0) |=>
    rf_reg[cex_pkg::PTR_DMA] == $past(rf_reg[cex_pkg::PTR_DMA]) + cex_pkg::INC)
    else $error("DMA out did not step the DMA pointer.");
  AST_IRQ_ENTRY: assert property (cyc_end && (state_reg == cex_pkg::ST_IRQ) |=>
    (t_reg == {$past(x_reg), $past(p_reg)}) && !irq_en_reg
    && (p_reg == cex_pkg::IRQ_P) && (x_reg == cex_pkg::IRQ_X))
    else $error("Interrupt entry did not save or set designators.");
  AST_DMA_PRIORITY: assert property (cyc_end && pin.dma_in_req && pin.dma_out_req
    && (state_reg != cex_pkg::ST_FETCH) && (state_reg != cex_pkg::ST_INIT)
    |=> (state_reg == cex_pkg::ST_DMA) && dir_in_reg)
    else $error("Output DMA was served before input DMA.");
  AST_LOAD_IDLE: assert property (load_mode && (state_reg == cex_pkg::ST_EXEC) |=>
    !o_timing_pulse_first && (o_addr == $past(rf_reg[cex_pkg::PTR_DMA]) - cex_pkg::INC))
    else $error("Load idle pulsed or addressed the wrong location.");
  AST_IDLE_HOLD: assert property (cyc_end && (state_reg == cex_pkg::ST_EXEC)
    && (opc_reg == cex_pkg::OP_IDLE) && !pin.dma_in_req && !pin.dma_out_req
    && !(pin.irq_req && irq_en_reg) |=> state_reg == cex_pkg::ST_EXEC)
    else $error("Idle was left without a request.");
  AST_INIT_CYCLE: assert property ((state_reg == cex_pkg::ST_INIT) |=>
    !o_timing_pulse_first && !o_timing_pulse_second)
    else $error("A timing pulse appeared in the initialization cycle.");
  AST_INIT_END: assert property (cyc_end && (state_reg == cex_pkg::ST_INIT) |=>
    irq_en_reg && (state_reg == cex_pkg::ST_EXEC))
    else $error("Initialization did not set enable or enter execute.");

endmodule : cex_exec

// ---- tb/cex_mem_model.sv ----
// Memory and I/O device model on the far side of the sequencer's bus.
module cex_mem_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_mem_read_n,
  input  wire logic        i_mem_write_n,
  input  wire logic        i_io_drive,
  input  wire logic [7:0]  i_io_data,
  output logic      [7:0]  o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] last_bus = 8'h00;
  // A released bus shows a pattern that changes every clock, never a held value.
  always_comb
  begin
    if (i_mem_read_n === 1'b0)
      o_bus = mem[i_addr[7:0]];
    else if (i_io_drive)
      o_bus = i_io_data;
    else
      o_bus = ~last_bus;
  end
  always @(posedge i_ref_clk)
  begin
    last_bus <= o_bus;
    if (i_mem_write_n === 1'b0)
      mem[i_addr[7:0]] <= o_bus;
  end
endmodule : cex_mem_model

// ---- tb/cpu_exec_dma_irq_cycles_test.sv ----
// Self-checking bench of the execute sequencer with a memory and I/O model.
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module cpu_exec_dma_irq_cycles_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst_n, clear_n, wait_n, dma_in, dma_out, irq, io_drive;
  logic [7:0]  io_data, bus, acc;
  logic [15:0] addr, seen_addr;
  logic        rd_n, wr_n, tpf, tps, carry, irq_en;
  logic        seen_rd, seen_wr, seen_tpf, seen_tps;
  logic [1:0]  st;
  int          seen_len, fail_count, check_count;
  logic [7:0]  prog [17] = '{8'h77, 8'hF8, 8'hA5, 8'hF9, 8'h0F, 8'hFA, 8'h3C, 8'hFB, 8'hFF,
                             8'hFC, 8'h40, 8'hFD, 8'h20, 8'hFF, 8'h10, 8'hFE, 8'h00};

  cex_exec i_cex_exec (
    .i_ref_clk             (ref_clk),
    .i_rst_n               (rst_n),
    .i_clear_n             (clear_n),
    .i_wait_n              (wait_n),
    .i_dma_in_req          (dma_in),
    .i_dma_out_req         (dma_out),
    .i_irq_req             (irq),
    .i_data                (bus),
    .o_addr                (addr),
    .o_mem_read_n          (rd_n),
    .o_mem_write_n         (wr_n),
    .o_timing_pulse_first  (tpf),
    .o_timing_pulse_second (tps),
    .o_state_code          (st),
    .o_acc                 (acc),
    .o_carry_flag          (carry),
    .o_irq_enable          (irq_en)
  );

  cex_mem_model i_cex_mem_model (
    .i_ref_clk     (ref_clk),
    .i_addr        (addr),
    .i_mem_read_n  (rd_n),
    .i_mem_write_n (wr_n),
    .i_io_drive    (io_drive),
    .i_io_data     (io_data),
    .o_bus         (bus)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Records strobes, pulses and the strobed address while the state code shows code.
  // The first two clocks are skipped for strobes; the previous cycle's read tail still shows under the old state code.
  task automatic observe(input logic [1:0] code, input int maxk);
    int n;
    n = 0;
    seen_len = 0;
    {seen_rd, seen_wr, seen_tpf, seen_tps} = 4'h0;
    seen_addr = 16'hFFFF;
    while (st !== code && n < 600)
    begin
      @(negedge ref_clk);
      n++;
    end
    while (st === code && seen_len < maxk)
    begin
      seen_tpf |= tpf;
      seen_tps |= tps;
      if (seen_len >= 2 && (rd_n === 1'b0 || wr_n === 1'b0))
      begin
        seen_addr = addr;
        seen_rd |= ~rd_n;
        seen_wr |= ~wr_n;
      end
      @(negedge ref_clk);
      seen_len++;
    end
    `CHK("state reached", 1'b1, n < 600)
  endtask : observe

  task automatic dma_cycle(input logic din, input logic dout, input logic [7:0] d);
    @(posedge ref_clk);
    dma_in <= din;
    dma_out <= dout;
    io_data <= d;
    io_drive <= din;
    fork
      observe(cex_pkg::SC_DMA, 16);
      begin
        wait (st === cex_pkg::SC_DMA);
        @(posedge ref_clk);
        dma_in <= 1'b0;
        dma_out <= 1'b0;
      end
    join
    @(posedge ref_clk);
    io_drive <= 1'b0;
  endtask : dma_cycle

  task automatic t_init;
    logic pulse;
    pulse = 1'b0;
    @(posedge ref_clk);
    clear_n <= 1'b1;
    repeat (11)
    begin
      @(negedge ref_clk);
      pulse |= tpf | tps;
    end
    `CHK("init pulses", 1'b0, pulse)
    repeat (13) @(negedge ref_clk);
    `CHK("init irq enable", 1'b1, irq_en)
    observe(cex_pkg::SC_EXEC, 40);
    `CHK("idle repeats", 40, seen_len)
    $display("init and idle test done");
  endtask : t_init

  task automatic t_program;
    logic [7:0] ea [8] = '{8'hA5, 8'hAF, 8'h2C, 8'hD3, 8'h13, 8'h0D, 8'hFD, 8'hFA};
    logic       ec [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    dma_cycle(1'b0, 1'b1, 8'h00);
    `CHK("dma out read", 1'b1, seen_rd)
    `CHK("dma out write", 1'b0, seen_wr)
    `CHK("dma out addr", 16'h0000, seen_addr)
    for (int i = 0; i < 8; i++)
    begin
      observe(cex_pkg::SC_EXEC, 16);
      repeat (2) @(negedge ref_clk);
      `CHK("acc", ea[i], acc)
      `CHK("carry", ec[i], carry)
      `CHK("exec read", i < 7, seen_rd)
      `CHK("exec write", 1'b0, seen_wr)
      `CHK("exec addr", (i < 7) ? 16'(2 + 2 * i) : 16'hFFFF, seen_addr)
    end
    $display("immediate and shift test done");
  endtask : t_program

  task automatic t_dma_irq;
    dma_cycle(1'b1, 1'b1, 8'hC3);
    `CHK("dma in write", 1'b1, seen_wr)
    `CHK("dma in read", 1'b0, seen_rd)
    `CHK("dma in addr", 16'h0011, seen_addr)
    `CHK("dma in data", 8'hC3, i_cex_mem_model.mem[17])
    `CHK("irq enable before", 1'b1, irq_en)
    @(posedge ref_clk);
    irq <= 1'b1;
    fork
      observe(cex_pkg::SC_IRQ, 16);
      begin
        wait (st === cex_pkg::SC_IRQ);
        @(posedge ref_clk);
        irq <= 1'b0;
      end
    join
    `CHK("irq strobes", 2'b00, {seen_rd, seen_wr})
    `CHK("irq enable after", 1'b0, irq_en)
    observe(cex_pkg::SC_FETCH, 16);
    `CHK("fetch from new counter", 16'h0000, seen_addr)
    $display("dma and interrupt test done");
  endtask : t_dma_irq

  task automatic t_load;
    repeat (400) @(posedge ref_clk);
    clear_n <= 1'b0;
    wait_n <= 1'b0;
    repeat (40) @(negedge ref_clk);
    observe(cex_pkg::SC_EXEC, 24);
    `CHK("load first pulse", 1'b0, seen_tpf)
    `CHK("load second pulse", 1'b1, seen_tps)
    `CHK("load addr", 16'h0012, seen_addr)
    dma_cycle(1'b1, 1'b0, 8'h5E);
    `CHK("load dma addr", 16'h0013, seen_addr)
    `CHK("load dma data", 8'h5E, i_cex_mem_model.mem[19])
    observe(cex_pkg::SC_EXEC, 24);
    `CHK("load addr after dma", 16'h0013, seen_addr)
    $display("load mode test done");
  endtask : t_load

  initial
  begin
    {rst_n, clear_n, dma_in, dma_out, irq, io_drive} = 6'h00;
    wait_n = 1'b1;
    io_data = 8'h00;
    fail_count = 0;
    check_count = 0;
    for (int i = 0; i < 256; i++)
      i_cex_mem_model.mem[i] = (i < 17) ? prog[i] : 8'h00;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_init;
    t_program;
    t_dma_irq;
    t_load;
    tally_and_finish;
  end

  initial
  begin
    repeat (6000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end
endmodule : cpu_exec_dma_irq_cycles_test
